// file: hw/cbc_top.sv
// host bus decode, result output and cascade flags of the cam
`timescale 1ns/1ps
`include "cbc_map.svh"

// Contract
// - select low: bus is entry index; high: bus is control code
// - random write sets entry validity from the validity line
// - control codes reach comparand, seven masks, and other registers
// - config holds page, direct-write mask choice, hw or sw control
// - sw control: instructions from data bus; memory only via address register or free write
// - either chip select low selects the device
// - device-select value equal to page with enable low also selects
// - result is page joined with match, free or random index
// - only highest responder drives result; none while enable high
// - lowest-priority device drives all ones on system mismatch
// - read or write puts accessed index on the result
// - result latched while strobe low, updates only while high
// - deselected compare discards earlier match and reports mismatch
// - status holds result, flags and two validation bits
// - hit and multi flags persist, change after compare strobe rise
// - multi line low on two hits, or chain low and a hit
// - advance code clears the top match to report the next one
// - full flag chains down; changes after write strobe rise
// - chain outputs ignore result enable and hold their values
// - chain high: hit flag low only on local hit; low: always low
// - full out high if chain high or any entry invalid
// - half select low picks bits 31-0, high picks 63-32
module cbc_top #(
  parameter int DEPTH = 4096,
  parameter int PAGE_W = 4,
  parameter int BUS_W = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycleStrobeN,
  input wire logic selectOneN,
  input wire logic selectTwoN,
  input wire logic writeN,
  input wire logic resultDriveEnN,
  input wire logic indexOrOpSel,
  input wire logic halfWordSel,
  input wire logic [BUS_W-1:0] opOrIndexBus,
  input wire logic [31:0] dataIn,
  input wire logic entryValidLine,
  input wire logic hitChainIn,
  input wire logic fullChainIn,
  output logic [31:0] dataOut,
  output logic dataOe,
  output logic validOut,
  output logic validOe,
  output logic [PAGE_W-1:0] bankNumberOut,
  output logic [$clog2(DEPTH)-1:0] hitIndexOut,
  output logic resultOe,
  output logic hitFlagOut,
  output logic tableFullOut,
  output logic multiHitOut,
  output logic multiHitOe
);
  import cbc_pkg::*;
  localparam int IW = $clog2(DEPTH);

  function automatic logic [IW-1:0] firstSet(input logic [DEPTH-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (v[i]) r = IW'(i);
    end
    return r;
  endfunction : firstSet

  ////////////////////////////////////////////////////////////////////////
  logic [63:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_ff, pendMatch_ff, matchVec_ff, hitVec;
  logic [63:0] comparand_ff;
  logic [31:0] maskReg_ff [8];
  logic [31:0] cfg_ff, dsel_ff, addrReg_ff, rdWord;
  logic [13:0] instr_ff;
  cbc_phase_t phase_ff, nxt_phase;
  cbc_src_t src_ff, pendSrc_ff;
  logic [IW-1:0] idx_ff, pendIdx_ff;
  logic pendUpd_ff, pendWr_ff, fullLatch_ff;
  logic [31:0] dataOut_ff;
  logic dataOe_ff, validOut_ff, validOe_ff, resultOe_ff;
  logic [PAGE_W-1:0] bankNumberOut_ff;
  logic [IW-1:0] hitIndexOut_ff;
  logic hitFlagOut_ff, tableFullOut_ff, multiHitOe_ff;

  ////////////////////////////////////////////////////////////////////////
  // strobe phase tracking
  always_comb begin
    case (phase_ff)
      PH_HIGH: nxt_phase = cycleStrobeN ? PH_HIGH : PH_LOW;
      PH_LOW: nxt_phase = cycleStrobeN ? PH_HIGH : PH_LOW;
      default: nxt_phase = PH_HIGH;
    endcase
  end
  wire take = (phase_ff == PH_HIGH) && !cycleStrobeN;
  wire rise = (phase_ff == PH_LOW) && cycleStrobeN;
  wire wr = !writeN;
  wire [PAGE_W-1:0] page = cfg_ff[PAGE_W-1:0];
  wire swMode = &cfg_ff[`CBC_CFG_SW_MSB:`CBC_CFG_SW_LSB];
  wire csSel = !selectOneN || !selectTwoN;
  wire dsSel = (dsel_ff[PAGE_W-1:0] == page) && !dsel_ff[`CBC_DSEL_EN];
  wire devSel = csSel || dsSel;
  // sw mode: select splits instruction and data
  wire ctlCyc = swMode || indexOrOpSel;
  wire instLoad = swMode && indexOrOpSel;
  wire [5:0] busOp = swMode ? instr_ff[5:0] : opOrIndexBus[5:0];
  wire [5:0] effOp = instLoad ? (wr ? dataIn[5:0] : `CBC_OP_STAT) : busOp;
  wire execOk = !(instLoad && wr) || (dataIn[5:0] == `CBC_OP_NEXT);
  wire [2:0] busMsel = swMode ? instr_ff[8:6] : opOrIndexBus[8:6];
  wire [2:0] msel = (instLoad && wr) ? dataIn[8:6] : busMsel;
  wire half_word_sel = swMode ? instr_ff[12] : halfWordSel;
  wire [31:0] cmpMask = maskReg_ff[msel];
  wire [IW-1:0] freeIdx = firstSet(~valid_ff);
  wire isFree = ctlCyc && execOk && (effOp == `CBC_OP_WRFREE);
  wire isIndir = ctlCyc && execOk && (effOp == `CBC_OP_INDIR);
  wire memOp = !ctlCyc || isIndir || (isFree && wr);
  wire [IW-1:0] memIdx = !ctlCyc ? opOrIndexBus[IW-1:0] :
                         (isFree ? freeIdx : addrReg_ff[IW-1:0]);
  // mask chosen by config for direct writes
  wire [2:0] cfgMsel = cfg_ff[`CBC_CFG_MSEL_MSB:`CBC_CFG_MSEL_LSB];
  wire [31:0] wrMask = !ctlCyc ? maskReg_ff[cfgMsel] : 32'h0000_0000;
  wire [63:0] oldWord = mem[memIdx];
  wire [31:0] oldHalf = half_word_sel ? oldWord[63:32] : oldWord[31:0];
  wire [31:0] newHalf = (oldHalf & wrMask) | (dataIn & ~wrMask);
  wire [63:0] newWord = half_word_sel ? {newHalf, oldWord[31:0]} :
                        {oldWord[63:32], newHalf};
  wire memWr = take && devSel && wr && memOp;
  wire regWr = take && devSel && wr && ctlCyc && execOk && !isFree;
  wire instWr = take && devSel && wr && instLoad;
  wire localHit = |matchVec_ff;
  wire multi = |(matchVec_ff & (matchVec_ff - 1'b1));
  wire [DEPTH-1:0] topBit = {{(DEPTH-1){1'b0}}, 1'b1} << idx_ff;
  wire isMask = (effOp >= `CBC_OP_MASK1) && (effOp <= `CBC_OP_MASK7);
  wire [31:0] statWord = {11'h000, src_ff, !multiHitOe_ff, tableFullOut_ff,
                          hitFlagOut_ff,
                          16'({bankNumberOut_ff, hitIndexOut_ff})};

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      hitVec[i] = valid_ff[i] && ((((half_word_sel ? mem[i][63:32] : mem[i][31:0]) ^
                  dataIn) & ~cmpMask) == 32'h0000_0000);
    end
  end

  always_comb begin
    rdWord = 32'h0000_0000;
    if (memOp) begin
      rdWord = oldHalf;
    end else if (isMask) begin
      rdWord = maskReg_ff[effOp[2:0]];
    end else begin
      case (effOp)
        `CBC_OP_CMPD: rdWord = half_word_sel ? comparand_ff[63:32] : comparand_ff[31:0];
        `CBC_OP_CFG: rdWord = cfg_ff;
        `CBC_OP_STAT: rdWord = statWord;
        `CBC_OP_ADDR: rdWord = addrReg_ff;
        `CBC_OP_DSEL: rdWord = dsel_ff;
        `CBC_OP_INSTR: rdWord = {18'h0_0000, instr_ff};
        default: rdWord = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (memWr) mem[memIdx] <= newWord;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comparand_ff <= 64'h0000_0000_0000_0000;
      for (int i = 0; i < 8; i++) maskReg_ff[i] <= 32'h0000_0000;
      cfg_ff <= `CBC_CFG_RST;
      dsel_ff <= `CBC_DSEL_RST;
      addrReg_ff <= 32'h0000_0000;
      instr_ff <= 14'h0000;
    end else begin
      // instruction loads even when it waits for a data cycle
      if (instWr) instr_ff <= dataIn[13:0];
      if (regWr) begin
        if (isMask) maskReg_ff[effOp[2:0]] <= dataIn;
        if (effOp == `CBC_OP_CMPD || effOp == `CBC_OP_CMP) begin
          if (half_word_sel) comparand_ff[63:32] <= dataIn;
          else comparand_ff[31:0] <= dataIn;
        end
        if (effOp == `CBC_OP_CFG) cfg_ff <= dataIn;
        if (effOp == `CBC_OP_ADDR) addrReg_ff <= dataIn;
        if (effOp == `CBC_OP_DSEL) dsel_ff <= dataIn;
        if (effOp == `CBC_OP_INSTR && !instLoad) instr_ff <= dataIn[13:0];
      end
    end
  end

  // match, validity and pending result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= PH_HIGH;
      valid_ff <= '0;
      pendMatch_ff <= '0;
      matchVec_ff <= '0;
      pendSrc_ff <= SRC_NONE;
      src_ff <= SRC_NONE;
      pendIdx_ff <= '0;
      idx_ff <= '0;
      pendUpd_ff <= 1'b0;
      pendWr_ff <= 1'b0;
      fullLatch_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      // validity from line, low means valid
      if (memWr) valid_ff[memIdx] <= !entryValidLine;
      if (memWr) pendWr_ff <= 1'b1;
      if (take && ctlCyc && execOk && effOp == `CBC_OP_CMP) begin
        pendMatch_ff <= devSel ? hitVec : '0;
        pendSrc_ff <= SRC_CMP;
        pendUpd_ff <= 1'b1;
      end else if (take && devSel && ctlCyc && effOp == `CBC_OP_NEXT) begin
        pendMatch_ff <= matchVec_ff & ~topBit;
        pendSrc_ff <= SRC_CMP;
        pendUpd_ff <= 1'b1;
      end else if (take && devSel && memOp) begin
        pendIdx_ff <= memIdx;
        pendSrc_ff <= isFree ? SRC_FREE : SRC_RAND;
        pendUpd_ff <= 1'b1;
      end
      if (rise && pendUpd_ff) begin
        src_ff <= pendSrc_ff;
        pendUpd_ff <= 1'b0;
        if (pendSrc_ff == SRC_CMP) begin
          matchVec_ff <= pendMatch_ff;
          idx_ff <= firstSet(pendMatch_ff);
        end else begin
          idx_ff <= pendIdx_ff;
        end
      end
      if (rise && pendWr_ff) begin
        fullLatch_ff <= &valid_ff;
        pendWr_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // only top responder drives
  wire isCmp = (src_ff == SRC_CMP);
  // lowest device answers a system mismatch
  wire missWin = isCmp && !localHit && hitChainIn && cfg_ff[`CBC_CFG_LOWEST];
  wire winner = (!isCmp && src_ff != SRC_NONE) ||
                (isCmp && localHit && hitChainIn) || missWin;
  wire allOnes = isCmp && !localHit;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataOut_ff <= 32'h0000_0000;
      dataOe_ff <= 1'b0;
      validOut_ff <= 1'b1;
      validOe_ff <= 1'b0;
      bankNumberOut_ff <= '0;
      hitIndexOut_ff <= '0;
      resultOe_ff <= 1'b0;
      hitFlagOut_ff <= 1'b1;
      tableFullOut_ff <= 1'b1;
      multiHitOe_ff <= 1'b0;
    end else begin
      if (take && devSel && !wr) begin
        dataOut_ff <= rdWord;
        dataOe_ff <= 1'b1;
        validOut_ff <= memOp ? !valid_ff[memIdx] : 1'b1;
        validOe_ff <= memOp;
      end else if (cycleStrobeN) begin
        dataOe_ff <= 1'b0;
        validOe_ff <= 1'b0;
      end
      // result moves only while strobe high
      if (cycleStrobeN) begin
        bankNumberOut_ff <= allOnes ? '1 : page;
        hitIndexOut_ff <= allOnes ? '1 : idx_ff;
      end
      resultOe_ff <= !resultDriveEnN && winner;
      // chain outputs free of the result enable
      hitFlagOut_ff <= !(localHit || !hitChainIn);
      multiHitOe_ff <= multi || (!hitChainIn && localHit);
      tableFullOut_ff <= fullChainIn || !fullLatch_ff;
    end
  end

  assign dataOut = dataOut_ff;
  assign dataOe = dataOe_ff;
  assign validOut = validOut_ff;
  assign validOe = validOe_ff;
  assign bankNumberOut = bankNumberOut_ff;
  assign hitIndexOut = hitIndexOut_ff;
  assign resultOe = resultOe_ff;
  assign hitFlagOut = hitFlagOut_ff;
  assign tableFullOut = tableFullOut_ff;
  assign multiHitOut = 1'b0;
  assign multiHitOe = multiHitOe_ff;
endmodule : cbc_top

// file: hw/cbc_map.svh
// offsets, field positions, codes and reset values of the cam bus block
`ifndef CBC_MAP_SVH
`define CBC_MAP_SVH
`define CBC_OP_CMPD 6'h00
`define CBC_OP_MASK1 6'h01
`define CBC_OP_MASK7 6'h07
`define CBC_OP_CFG 6'h08
`define CBC_OP_STAT 6'h09
`define CBC_OP_ADDR 6'h0a
`define CBC_OP_DSEL 6'h0b
`define CBC_OP_INSTR 6'h0c
`define CBC_OP_CMP 6'h10
`define CBC_OP_NEXT 6'h11
`define CBC_OP_WRFREE 6'h12
`define CBC_OP_INDIR 6'h13
`define CBC_CFG_MSEL_LSB 4
`define CBC_CFG_MSEL_MSB 6
`define CBC_CFG_LOWEST 7
`define CBC_CFG_SW_LSB 26
`define CBC_CFG_SW_MSB 27
`define CBC_DSEL_EN 4
`define CBC_CFG_RST 32'h0000_0000
`define CBC_DSEL_RST 32'h0000_0010
`define CBC_STAT_HIT 16
`define CBC_STAT_FULL 17
`define CBC_STAT_MULTI 18
`define CBC_STAT_SRC_LSB 19
`endif

// file: hw/cbc_pkg.sv
// types of the cam bus block
package cbc_pkg;
  typedef enum logic [1:0] {
    PH_HIGH = 2'b01,
    PH_LOW = 2'b10
  } cbc_phase_t;
  // result source, also the two validation bits
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_CMP = 2'b01,
    SRC_RAND = 2'b10,
    SRC_FREE = 2'b11
  } cbc_src_t;
endpackage : cbc_pkg

// file: tb/cbc_upstream.sv
// higher-priority cascade neighbour and the wired multi-hit line
`timescale 1ns/1ps
module cbc_upstream (
  input wire logic upHit,
  input wire logic upNotFull,
  input wire logic multiHitOe,
  input wire logic multiHitOut,
  output logic hitChainIn,
  output logic fullChainIn,
  output logic multiWire
);
  // upper flags, top-device levels by default
  assign hitChainIn = !upHit;
  assign fullChainIn = upNotFull;
  assign multiWire = multiHitOe ? multiHitOut : 1'b1;
endmodule : cbc_upstream

// file: tb/cbc_top_monitor.sv
// port assertions of the cam bus block
`timescale 1ns/1ps
module cbc_top_monitor #(
  parameter int DEPTH = 4096,
  parameter int PAGE_W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cycleStrobeN,
  input wire logic selectOneN,
  input wire logic selectTwoN,
  input wire logic writeN,
  input wire logic resultDriveEnN,
  input wire logic hitChainIn,
  input wire logic fullChainIn,
  input wire logic dataOe,
  input wire logic [PAGE_W-1:0] bankNumberOut,
  input wire logic [$clog2(DEPTH)-1:0] hitIndexOut,
  input wire logic resultOe,
  input wire logic hitFlagOut,
  input wire logic tableFullOut,
  input wire logic multiHitOut,
  input wire logic multiHitOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_CHAIN_HIT: assert property (!hitChainIn |=> !hitFlagOut)
    else $error("hit flag high with chain low");
  AST_FULL_CHAIN: assert property (fullChainIn |=> tableFullOut)
    else $error("full flag low with chain high");
  AST_OE_OFF: assert property (resultDriveEnN |=> !resultOe)
    else $error("result driven with enable high");
  AST_OE_CAUSE: assert property (
    $rose(resultOe) |-> $past(!resultDriveEnN))
    else $error("result drive without enable");
  AST_RES_HOLD: assert property (!cycleStrobeN |=>
    $stable({bankNumberOut, hitIndexOut}))
    else $error("result moved while strobe low");
  AST_HIT_HOLD: assert property (
    (!cycleStrobeN && hitChainIn) [*2] |=>
    $stable(hitFlagOut) && $stable(multiHitOe))
    else $error("hit flags moved while strobe low");
  AST_READ_OE: assert property ($fell(cycleStrobeN) && writeN &&
    !(selectOneN && selectTwoN) |=> dataOe)
    else $error("selected read not driven");
  AST_NOSEL: assert property ($fell(cycleStrobeN) && selectOneN &&
    selectTwoN |=> !dataOe)
    else $error("unselected cycle drove data");
  AST_OD_LOW: assert property (multiHitOe |-> !multiHitOut)
    else $error("multi line driven high");
  COV_HIT: cover property ($fell(hitFlagOut));
  COV_MULTI: cover property ($rose(multiHitOe));
  COV_FULL: cover property ($fell(tableFullOut));
endmodule : cbc_top_monitor

bind cbc_top cbc_top_monitor #(.DEPTH(DEPTH), .PAGE_W(PAGE_W)) mon_u (
  .clk(clk), .nrst(nrst), .cycleStrobeN(cycleStrobeN),
  .selectOneN(selectOneN), .selectTwoN(selectTwoN), .writeN(writeN),
  .resultDriveEnN(resultDriveEnN), .hitChainIn(hitChainIn),
  .fullChainIn(fullChainIn), .dataOe(dataOe), .bankNumberOut(bankNumberOut),
  .hitIndexOut(hitIndexOut), .resultOe(resultOe), .hitFlagOut(hitFlagOut),
  .tableFullOut(tableFullOut), .multiHitOut(multiHitOut),
  .multiHitOe(multiHitOe));

// file: tb/testbench.sv
// self-checking bench of the cam bus block
`timescale 1ns/1ps
module testbench;
  localparam logic [1:0] SEL = 2'b10;
  localparam logic [1:0] SEL2 = 2'b01;
  localparam logic [1:0] NOSEL = 2'b11;
  localparam logic [31:0] KEY = 32'ha5a5_0001;
  logic clk, nrst, cycleStrobeN, selectOneN, selectTwoN, writeN;
  logic resultDriveEnN, indexOrOpSel, halfWordSel, entryValidLine;
  logic upHit, upNotFull, dataOe, validOut, validOe, resultOe;
  logic hitFlagOut, tableFullOut, multiHitOut, multiHitOe, rdOe, rdValid;
  logic hitChainIn, fullChainIn, multiWire;
  logic [11:0] opOrIndexBus;
  logic [31:0] dataIn, dataOut, rdData;
  logic [3:0] bankNumberOut, hitIndexOut;
  int fail_count, n_checks;
  ////////////////////////////////////////////////////////////////////////
  cbc_top #(.DEPTH(16), .PAGE_W(4), .BUS_W(12)) dut_u (
    .clk(clk), .nrst(nrst), .cycleStrobeN(cycleStrobeN),
    .selectOneN(selectOneN), .selectTwoN(selectTwoN), .writeN(writeN),
    .resultDriveEnN(resultDriveEnN), .indexOrOpSel(indexOrOpSel),
    .halfWordSel(halfWordSel), .opOrIndexBus(opOrIndexBus), .dataIn(dataIn),
    .entryValidLine(entryValidLine), .hitChainIn(hitChainIn),
    .fullChainIn(fullChainIn), .dataOut(dataOut), .dataOe(dataOe),
    .validOut(validOut), .validOe(validOe), .bankNumberOut(bankNumberOut),
    .hitIndexOut(hitIndexOut), .resultOe(resultOe), .hitFlagOut(hitFlagOut),
    .tableFullOut(tableFullOut), .multiHitOut(multiHitOut),
    .multiHitOe(multiHitOe));
  cbc_upstream up_u (.upHit(upHit), .upNotFull(upNotFull),
    .multiHitOe(multiHitOe), .multiHitOut(multiHitOut),
    .hitChainIn(hitChainIn), .fullChainIn(fullChainIn),
    .multiWire(multiWire));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one strobe-framed bus cycle, result settled at return
  task automatic cyc(input logic ctl, input logic wr, input logic hs,
      input logic [1:0] sn, input logic [11:0] bus, input logic [31:0] d,
      input logic vn);
    @(negedge clk);
    cycleStrobeN = 0;
    indexOrOpSel = ctl;
    writeN = !wr;
    halfWordSel = hs;
    {selectTwoN, selectOneN} = sn;
    opOrIndexBus = bus;
    dataIn = d;
    entryValidLine = vn;
    repeat (2) @(negedge clk);
    rdData = dataOut;
    rdOe = dataOe;
    rdValid = validOut;
    cycleStrobeN = 1;
    repeat (4) @(negedge clk);
  endtask : cyc
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    {nrst, selectOneN, selectTwoN, writeN, indexOrOpSel} = 5'b0_1111;
    {cycleStrobeN, resultDriveEnN, halfWordSel, entryValidLine} = 4'b1001;
    {upHit, upNotFull, opOrIndexBus, dataIn} = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (10) @(negedge clk);
    nrst = 1;
    // entry writes, both halves
    cyc(0, 1, 0, SEL, 12'h005, KEY, 0);
    chk({bankNumberOut, hitIndexOut}, 8'h05);
    chk(resultOe, 1'b1);
    cyc(0, 1, 1, SEL2, 12'h005, 32'h5a5a_0002, 0);
    cyc(0, 1, 0, SEL, 12'h002, 32'h0000_1234, 1);
    chk(tableFullOut, 1'b1);
    cyc(0, 0, 1, SEL, 12'h005, '0, 0);
    chk(rdData, 32'h5a5a_0002);
    cyc(0, 0, 0, SEL, 12'h005, '0, 0);
    chk({rdOe, rdValid}, 2'b10);
    chk(rdData, KEY);
    cyc(0, 0, 0, SEL, 12'h002, '0, 0);
    chk(rdValid, 1'b1);
    cyc(0, 0, 0, NOSEL, 12'h005, '0, 0);
    chk(rdOe, 1'b0);
    // mask registers through control codes
    for (int i = 1; i < 8; i++) cyc(1, 1, 0, SEL, 12'(i), 32'h0f0f_0000 + i, 0);
    for (int i = 1; i < 8; i++) begin
      cyc(1, 0, 0, SEL, 12'(i), '0, 0);
      chk(rdData, 32'h0f0f_0000 + i);
    end
    // compare with one hit, then two
    cyc(1, 1, 0, SEL, 12'h010, KEY, 0);
    chk({hitFlagOut, multiHitOe, hitIndexOut}, 6'h05);
    cyc(0, 1, 0, SEL, 12'h009, KEY, 0);
    cyc(1, 1, 0, SEL, 12'h010, KEY, 0);
    chk({multiWire, hitIndexOut}, 5'h05);
    cyc(1, 1, 0, SEL, 12'h011, '0, 0);
    chk(hitIndexOut, 4'h9);
    // deselected compare drops the hit
    cyc(1, 1, 0, NOSEL, 12'h010, KEY, 0);
    chk(hitFlagOut, 1'b1);
    upHit = 1;
    repeat (2) @(negedge clk);
    chk(hitFlagOut, 1'b0);
    upHit = 0;
    // lowest-priority device, page 3
    cyc(1, 1, 0, SEL, 12'h008, 32'h0000_0083, 0);
    cyc(1, 1, 0, SEL, 12'h010, 32'h1111_1111, 0);
    chk({hitFlagOut, bankNumberOut, hitIndexOut}, 9'h1ff);
    cyc(0, 0, 0, SEL, 12'h009, '0, 0);
    chk({bankNumberOut, hitIndexOut}, 8'h39);
    resultDriveEnN = 1;
    repeat (2) @(negedge clk);
    chk(resultOe, 1'b0);
    resultDriveEnN = 0;
    // fill every entry, then raise the upstream chain
    for (int i = 0; i < 16; i++) cyc(0, 1, 0, SEL, 12'(i), i, 0);
    chk(tableFullOut, 1'b0);
    upNotFull = 1;
    repeat (2) @(negedge clk);
    chk(tableFullOut, 1'b1);
    // software control, page 3 and lowest kept
    cyc(1, 1, 0, SEL, 12'h008, 32'h0c00_0083, 0);
    resultDriveEnN = 1;
    cyc(1, 1, 0, SEL, 12'h000, 32'h0000_0010, 0);
    cyc(0, 1, 0, SEL, 12'h000, 32'h0000_0007, 0);
    chk({hitFlagOut, bankNumberOut, hitIndexOut}, 9'h037);
    chk(resultOe, 1'b0);
    resultDriveEnN = 0;
    repeat (2) @(negedge clk);
    chk(resultOe, 1'b1);
    cyc(1, 0, 0, SEL, 12'h000, '0, 0);
    chk(rdData, 32'h000e_0037);
    end_sim;
  end
endmodule : testbench
